// File: subtract_with_carry_unit.sv
// subtract-from datapath with register file and ahb-lite register port
`include "subtract_with_carry_unit_regs.svh"

module subtract_with_carry_unit (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic subtract_with_carry_unit_pkg::insn_t split_insn(
    input logic [31:0] w
  );
    subtract_with_carry_unit_pkg::insn_t f;
    f.primary           = w[31:26]; // RULE_08
    f.dest_reg          = w[25:21];
    f.first_source_reg  = w[20:16];
    f.second_source_reg = w[15:11];
    f.ov_enable         = w[10];
    f.ext_op            = w[9:1];
    f.record_bit        = w[0];
    return f;
  endfunction

  function automatic subtract_with_carry_unit_pkg::op_t op_of(
    input subtract_with_carry_unit_pkg::insn_t f
  );
    subtract_with_carry_unit_pkg::op_t o;
    o = subtract_with_carry_unit_pkg::OP_ILLEGAL;
    if (f.primary == `PRIMARY_ARITH) begin
      case (f.ext_op)
        `XO_SUB_PLAIN: o = subtract_with_carry_unit_pkg::OP_SUB_PLAIN;
        `XO_SUB_CARRY: o = subtract_with_carry_unit_pkg::OP_SUB_CARRY;
        `XO_SUB_EXT:   o = subtract_with_carry_unit_pkg::OP_SUB_EXT;
        `XO_SUB_M1:    o = subtract_with_carry_unit_pkg::OP_SUB_M1;
        `XO_SUB_ZERO:  o = subtract_with_carry_unit_pkg::OP_SUB_ZERO;
        default:       o = subtract_with_carry_unit_pkg::OP_ILLEGAL;
      endcase
      // single-operand forms keep the second source field reserved
      if ((o == subtract_with_carry_unit_pkg::OP_SUB_M1 ||
           o == subtract_with_carry_unit_pkg::OP_SUB_ZERO) &&
          f.second_source_reg != 5'h00)
        o = subtract_with_carry_unit_pkg::OP_ILLEGAL;
    end
    return o;
  endfunction

  function automatic logic is_legal(
    input subtract_with_carry_unit_pkg::op_t o
  );
    return o != subtract_with_carry_unit_pkg::OP_ILLEGAL;
  endfunction

  function automatic logic in_gpr_window(
    input logic [7:0] a
  );
    return a[`GPR_BASE_BIT];
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // thirty-two words: the whole register file lives in this block
  logic [31:0] gpr_r [32];
  logic [31:0] insn_r;
  subtract_with_carry_unit_pkg::flags_t flags_r;
  logic [4:0]  last_rt_r;
  logic        illegal_r;
  logic        done_r;

  // read handshake: one wait state, then the word is held
  subtract_with_carry_unit_pkg::bus_state_t bus_state_r;
  logic        wr_pend_r;
  logic [7:0]  addr_r;
  logic [31:0] hrdata_r;
  logic        hreadyout_r;
  logic        hresp_r;

  // ----------------------------------------------------------------
  // address phase
  // ----------------------------------------------------------------
  logic take;
  logic wr_data;
  logic exec;
  logic flags_wr;
  logic gpr_wr;

  // hsize is not checked: only whole-word transfers are supported
  assign take     = hsel && hready && htrans[1];
  assign wr_data  = wr_pend_r;
  assign exec     = wr_data && addr_r == `OFS_INSN;
  assign flags_wr = wr_data && addr_r == `OFS_FLAGS;
  assign gpr_wr   = wr_data && in_gpr_window(addr_r);

  // write data arrive one cycle after the address is taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      addr_r    <= 8'h00;
    end else begin
      wr_pend_r <= take && hwrite;
      if (take)
        addr_r <= haddr[7:0];
    end
  end

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  subtract_with_carry_unit_pkg::insn_t f;
  subtract_with_carry_unit_pkg::op_t   op;
  logic [31:0] ra_val;
  logic [31:0] rb_val;
  logic [31:0] add_a;
  logic [31:0] add_b;
  logic        cin;
  logic [32:0] sum;
  logic        ov;
  logic        new_so;
  logic [3:0]  cr0;
  logic        legal;

  assign f      = split_insn(hwdata);
  assign op     = op_of(f);
  assign legal  = is_legal(op);
  // operands come straight from the register file in the data phase
  assign ra_val = gpr_r[f.first_source_reg];
  assign rb_val = gpr_r[f.second_source_reg];

  // the swapped alias needs no logic: its fields arrive exchanged
  always_comb begin
    add_a = ~ra_val; // RULE_07
    add_b = rb_val;
    cin   = 1'b1;
    case (op)
      subtract_with_carry_unit_pkg::OP_SUB_EXT: begin
        cin = flags_r.carry_flag; // RULE_01
      end
      subtract_with_carry_unit_pkg::OP_SUB_M1: begin
        add_b = 32'hffff_ffff; // RULE_03
        cin   = flags_r.carry_flag;
      end
      subtract_with_carry_unit_pkg::OP_SUB_ZERO: begin
        add_b = 32'h0000_0000; // RULE_04
        cin   = flags_r.carry_flag;
      end
      default: begin
        cin = 1'b1;
      end
    endcase
  end

  // one 33-bit adder serves every form; bit 32 is the carry-out
  assign sum    = {1'b0, add_a} + {1'b0, add_b} + {32'h0000_0000, cin};
  assign ov     = (add_a[31] == add_b[31]) && (sum[31] != add_a[31]);
  assign new_so = f.ov_enable ? (flags_r.so | ov) : flags_r.so;
  // lt, gt, eq, then the summary copy
  assign cr0    = {sum[31], !sum[31] && sum[31:0] != 32'h0000_0000,
                   sum[31:0] == 32'h0000_0000, new_so};

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 32; i++)
        gpr_r[i] <= `RST_WORD;
    end else if (exec && legal) begin
      // execute and software write never share an edge: one data phase each
      gpr_r[f.dest_reg] <= sum[31:0];
    end else if (gpr_wr) begin
      gpr_r[addr_r[6:2]] <= hwdata;
    end
  end

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_r <= '0;
    end else if (exec && legal) begin
      // flag writes come in their own data phase, so they never collide
      if (op != subtract_with_carry_unit_pkg::OP_SUB_PLAIN)
        flags_r.carry_flag <= sum[32]; // RULE_02
      if (f.ov_enable) begin
        flags_r.ov <= ov; // RULE_06
        flags_r.so <= new_so; // RULE_06
      end
      if (f.record_bit)
        flags_r.condition_field_zero <= cr0; // RULE_05
    end else if (flags_wr) begin
      flags_r.carry_flag           <= hwdata[`FLG_CARRY];
      flags_r.ov                   <= hwdata[`FLG_OV];
      flags_r.so                   <= hwdata[`FLG_SO];
      flags_r.condition_field_zero <= hwdata[`FLG_CR0_HI:`FLG_CR0_LO];
    end
  end

  // ----------------------------------------------------------------
  // instruction and status
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      insn_r    <= `RST_WORD;
      last_rt_r <= 5'h00;
      illegal_r <= 1'b0;
      done_r    <= 1'b0;
    end else if (exec) begin
      insn_r    <= hwdata;
      last_rt_r <= f.dest_reg;
      // kept for illegal words too, so software can see why nothing moved
      illegal_r <= !legal;
      done_r    <= legal;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // one wait state on reads lets a write in the previous data phase land
  // first, at the cost of one cycle per read
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (in_gpr_window(addr_r)) begin
      rd_word = gpr_r[addr_r[6:2]];
    end else begin
      case (addr_r)
        `OFS_INSN:   rd_word = insn_r;
        `OFS_FLAGS: begin
          rd_word[`FLG_CARRY]               = flags_r.carry_flag;
          rd_word[`FLG_OV]                  = flags_r.ov;
          rd_word[`FLG_SO]                  = flags_r.so;
          rd_word[`FLG_CR0_HI:`FLG_CR0_LO]  = flags_r.condition_field_zero;
        end
        `OFS_STATUS: begin
          rd_word[`STS_RT_HI:0]  = last_rt_r;
          rd_word[`STS_ILLEGAL]  = illegal_r;
          rd_word[`STS_DONE]     = done_r;
        end
        default:     rd_word = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state_r <= subtract_with_carry_unit_pkg::BUS_IDLE;
      hreadyout_r <= 1'b1;
      hrdata_r    <= `RST_WORD;
    end else begin
      case (bus_state_r)
        subtract_with_carry_unit_pkg::BUS_IDLE: begin
          if (take && !hwrite) begin
            bus_state_r <= subtract_with_carry_unit_pkg::BUS_RD;
            hreadyout_r <= 1'b0;
          end
        end
        subtract_with_carry_unit_pkg::BUS_RD: begin
          bus_state_r <= subtract_with_carry_unit_pkg::BUS_IDLE;
          hreadyout_r <= 1'b1;
          hrdata_r    <= rd_word;
        end
        default: begin
          bus_state_r <= subtract_with_carry_unit_pkg::BUS_IDLE;
          hreadyout_r <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // response
  // ----------------------------------------------------------------
  // no error case exists, but a flop keeps every port launched by a register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_r <= 1'b0;
    end else begin
      hresp_r <= 1'b0;
    end
  end

  assign hrdata    = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp     = hresp_r;

endmodule // subtract_with_carry_unit

// File: subtract_with_carry_unit_monitor.sv
// bus timing checker for the subtract unit register port
module subtract_with_carry_unit_monitor (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // ahb-lite slave side
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic tk;
  assign tk = hsel && hready && htrans[1];
  sequence s_rd; tk && !hwrite; endsequence
  sequence s_wait; !hreadyout ##1 hreadyout; endsequence
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("hresp not okay");
  property p_rd; s_rd |=> s_wait; endproperty
  a_rd: assert property (p_rd) else $error("read wait state wrong");
  property p_wr; tk && hwrite |=> hreadyout; endproperty
  a_wr: assert property (p_wr) else $error("write stalled");
  property p_one; !hreadyout |=> hreadyout; endproperty
  a_one: assert property (p_one) else $error("wait longer than one cycle");
  property p_fall; $fell(hreadyout) |-> $past(tk) && !$past(hwrite); endproperty
  a_fall: assert property (p_fall) else $error("stall without read");
  property p_hold; $changed(hrdata) |-> $rose(hreadyout); endproperty
  a_hold: assert property (p_hold) else $error("hrdata moved outside read");
  property p_unmap; s_rd and haddr[7:0] inside {[8'h0c:8'h7c]} |-> ##2 hrdata == 32'h0000_0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_sts; s_rd and haddr[7:0] == 8'h08 |-> ##2 hrdata[31:10] == 22'h0; endproperty
  a_sts: assert property (p_sts) else $error("status high bits set");
endmodule // subtract_with_carry_unit_monitor

// File: subtract_with_carry_unit_pkg.sv
// types shared by the subtract unit
package subtract_with_carry_unit_pkg;

  typedef struct packed {
    logic [5:0] primary;
    logic [4:0] dest_reg;
    logic [4:0] first_source_reg;
    logic [4:0] second_source_reg;
    logic       ov_enable;
    logic [8:0] ext_op;
    logic       record_bit;
  } insn_t;

  typedef enum logic [5:0] {
    OP_SUB_PLAIN = 6'b00_0001,
    OP_SUB_CARRY = 6'b00_0010,
    OP_SUB_EXT   = 6'b00_0100,
    OP_SUB_M1    = 6'b00_1000,
    OP_SUB_ZERO  = 6'b01_0000,
    OP_ILLEGAL   = 6'b10_0000
  } op_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RD   = 2'b10
  } bus_state_t;

  typedef struct packed {
    logic       carry_flag;
    logic       ov;
    logic       so;
    logic [3:0] condition_field_zero;
  } flags_t;

endpackage

// File: subtract_with_carry_unit_regs.svh
// register offsets, field positions and reset values of the subtract unit
// Overview of operation
// RULE_01: extended subtract: not first plus second plus carry
// RULE_02: carry set when unsigned sum exceeds 32 bits
// RULE_03: minus-one form: not first plus ones plus carry
// RULE_04: zero form: not first plus carry only
// RULE_05: record bit set updates condition field zero
// RULE_06: overflow-enable set updates overflow and summary flags
// RULE_07: swapped alias: not second plus first plus one
// RULE_08: decode fields from conventional instruction bit positions
`ifndef SUBTRACT_WITH_CARRY_UNIT_REGS_SVH
`define SUBTRACT_WITH_CARRY_UNIT_REGS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define OFS_INSN      8'h00
`define OFS_FLAGS     8'h04
`define OFS_STATUS    8'h08
`define GPR_BASE_BIT  7

// ----------------------------------------------------------------
// flags register fields
// ----------------------------------------------------------------
`define FLG_CARRY     0
`define FLG_OV        1
`define FLG_SO        2
`define FLG_CR0_LO    4
`define FLG_CR0_HI    7

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define STS_RT_HI     4
`define STS_ILLEGAL   8
`define STS_DONE      9

// ----------------------------------------------------------------
// instruction encodings
// ----------------------------------------------------------------
`define PRIMARY_ARITH 6'h1f
`define XO_SUB_PLAIN  9'd40
`define XO_SUB_CARRY  9'd8
`define XO_SUB_EXT    9'd136
`define XO_SUB_ZERO   9'd200
`define XO_SUB_M1     9'd232

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_WORD      32'h0000_0000

`endif

// File: test_subtract_with_carry_unit.sv
// self-checking bench for the subtract unit
`include "subtract_with_carry_unit_regs.svh"
module test_subtract_with_carry_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  int          errors = 0;
  int          check_count = 0;
  subtract_with_carry_unit uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  initial forever #4 hclk = ~hclk;
  task automatic complete_run;
    if (errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // hready is settled at the falling edge, same value the next rising edge samples
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    if (hreadyout !== 1'b1) begin
      errors++;
      complete_run();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= 2'h2;
    wait_rdy();
    @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    @(posedge hclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0000_0000, q);
  endtask
  // r1 = a, r2 = b, result lands in r3
  task automatic ex(input logic [8:0] xo, input logic [31:0] a, b, input logic [7:0] f0, input logic oe, rc);
    logic [31:0] ad, r, g;
    logic [32:0] s;
    logic        ci, v, so;
    logic [7:0]  fe;
    logic [4:0]  rb;
    ad = (xo == `XO_SUB_M1) ? 32'hffff_ffff : (xo == `XO_SUB_ZERO) ? 32'h0000_0000 : b;
    ci = (xo == `XO_SUB_CARRY || xo == `XO_SUB_PLAIN) ? 1'b1 : f0[0];
    rb = (xo == `XO_SUB_M1 || xo == `XO_SUB_ZERO) ? 5'h00 : 5'h02;
    s = {1'b0, ~a} + {1'b0, ad} + {32'h0, ci};
    r = s[31:0];
    v = (~a[31] == ad[31]) && (r[31] != ad[31]);
    so = f0[2] | (oe & v);
    fe = f0;
    if (xo != `XO_SUB_PLAIN) fe[0] = s[32];
    if (oe) fe[2:1] = {so, v};
    if (rc) fe[7:4] = {r[31], !r[31] && r != 0, r == 0, so};
    wr(8'h84, a);
    wr(8'h88, b);
    wr(8'h04, {24'h0, f0});
    wr(8'h00, {6'h1f, 5'h03, 5'h01, rb, oe, xo, rc});
    rd(8'h8c, g);
    chk("result", r, g);
    rd(8'h04, g);
    chk("flags", {24'h0, fe}, g);
    rd(8'h08, g);
    chk("status", 32'h0000_0203, g);
  endtask
  task automatic t_ext;
    ex(`XO_SUB_EXT, 32'h0000_0005, 32'h0000_0003, 8'h01, 1'b1, 1'b1);
    ex(`XO_SUB_EXT, 32'h0000_0000, 32'h0000_0000, 8'hf6, 1'b0, 1'b0);
    ex(`XO_SUB_EXT, 32'h0000_0005, 32'h0000_0003, 8'h06, 1'b1, 1'b1);
  endtask
  task automatic t_carry;
    ex(`XO_SUB_CARRY, 32'h0000_0000, 32'h0000_0000, 8'h00, 1'b0, 1'b1);
    ex(`XO_SUB_CARRY, 32'h0000_0001, 32'h0000_0000, 8'h01, 1'b0, 1'b1);
    ex(`XO_SUB_CARRY, 32'hffff_ffff, 32'h7fff_ffff, 8'h00, 1'b1, 1'b1);
    ex(`XO_SUB_PLAIN, 32'h0000_0002, 32'h0000_0009, 8'h01, 1'b0, 1'b0);
  endtask
  task automatic t_m1_zero;
    ex(`XO_SUB_M1, 32'h0000_0000, 32'h1234_5678, 8'h01, 1'b1, 1'b1);
    ex(`XO_SUB_M1, 32'hffff_ffff, 32'h0000_0000, 8'h00, 1'b0, 1'b1);
    ex(`XO_SUB_ZERO, 32'hffff_ffff, 32'h0000_0000, 8'h01, 1'b1, 1'b0);
    ex(`XO_SUB_ZERO, 32'h0000_0000, 32'h0000_0000, 8'h05, 1'b0, 1'b1);
  endtask
  // operand swap is done by software, so feed the fields crosswise
  task automatic t_swap;
    logic [31:0] g;
    ex(`XO_SUB_CARRY, 32'h0000_0030, 32'h0000_0010, 8'h00, 1'b1, 1'b1);
    wr(8'h84, 32'h0000_0030);
    wr(8'h88, 32'h0000_0010);
    wr(8'h04, 32'h0000_0000);
    wr(8'h00, {6'h1f, 5'h03, 5'h02, 5'h01, 1'b1, `XO_SUB_CARRY, 1'b1});
    rd(8'h8c, g);
    chk("swap result", 32'h0000_0020, g);
    rd(8'h04, g);
    chk("swap flags", 32'h0000_0041, g);
  endtask
  task automatic t_bad;
    logic [31:0] g;
    wr(8'h8c, 32'hcafe_0001);
    wr(8'h00, {6'h1e, 5'h03, 5'h01, 5'h02, 1'b0, `XO_SUB_EXT, 1'b0});
    rd(8'h8c, g);
    chk("illegal result", 32'hcafe_0001, g);
    rd(8'h08, g);
    chk("illegal status", 32'h0000_0100, {22'h0, g[9:8], 8'h00});
    wr(8'h04, 32'h0000_0001);
    wr(8'h00, {6'h1f, 5'h04, 5'h01, 5'h02, 1'b0, `XO_SUB_M1, 1'b0});
    rd(8'h00, g);
    chk("insn readback", {6'h1f, 5'h04, 5'h01, 5'h02, 1'b0, `XO_SUB_M1, 1'b0}, g);
    rd(8'h90, g);
    chk("reserved form result", 32'h0000_0000, g);
    rd(8'h04, g);
    chk("illegal flags", 32'h0000_0001, g);
    rd(8'h08, g);
    chk("reserved form status", 32'h0000_0104, g);
    wr(8'h40, 32'hdead_beef);
    rd(8'h40, g);
    chk("unmapped", 32'h0000_0000, g);
  endtask
  task automatic t_reset;
    logic [31:0] g;
    wr(8'h8c, 32'h0000_5a5a);
    rd(8'h8c, g);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("reset hrdata", 32'h0000_0000, hrdata);
    chk("reset hreadyout", 32'h0000_0001, {31'h0, hreadyout});
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(8'h8c, g);
    chk("reset gpr", 32'h0000_0000, g);
    rd(8'h04, g);
    chk("reset flags", 32'h0000_0000, g);
  endtask
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_ext();
    t_carry();
    t_m1_zero();
    t_swap();
    t_bad();
    t_reset();
    complete_run();
  end
endmodule // test_subtract_with_carry_unit
bind subtract_with_carry_unit subtract_with_carry_unit_monitor mon (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
